/* File: core/epw_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - single-output configuration behaves as plain one-channel pwm, no dead band
// - pins driven per pattern: a only, a and b, or all four
// - half-bridge delays inactive-to-active edges by dead band; falling edges undelayed
// - dead band equals the 7-bit count in instruction cycles
// - shutdown sources: comparator one, comparator two, low fault input, any mix
// - source select of zero disables auto-shutdown entirely
// - shutdown states applied asynchronously; per pair high, low or tri-state
// - hardware sets shutdown flag on event; outputs held while flag set
// - auto-restart clears flag when cause gone, else firmware clears it
// - flag set at period start keeps shutdown all period; resume next period
// - software writes to flag ignored while shutdown condition present
// - restart-enable bit seven selects automatic or software flag clear
// - shutdown applies only in enhanced pwm modes, only to active outputs
// - on variants without half-bridge the delay count reads zero
// - output configuration selects single, forward, half-bridge or reverse
// - mode bit one inverts pair a/c, bit zero inverts pair b/d
module epw_top
#(
   parameter bit HAS_HALF_BRIDGE = 1'b1
)
(
   input wire logic clk,
   input wire logic srst,
   input wire epw_pkg::epw_bus_s bus,
   output logic [7:0] rdata,
   input wire logic pwm_raw,
   input wire logic period_start,
   input wire logic cmp1_trip,
   input wire logic cmp2_trip,
   input wire logic fault_input_n,
   output epw_pkg::epw_pins_s pin_out,
   output epw_pkg::epw_pins_s pin_oe,
   output logic irq
);
   import epw_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers (pwm_raw and period_start come from timer logic on clk)
   logic [2:0] trip_meta;
   logic [2:0] trip_sync;
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         trip_meta <= 3'h0;
         trip_sync <= 3'h0;
      end
      else
      begin
         trip_meta <= {~fault_input_n, cmp2_trip, cmp1_trip};
         trip_sync <= trip_meta;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers
   logic [7:0] unit_control_reg;
   logic [6:0] shdn_cfg; // source select and pair states
   logic shutdown_active_flag;
   logic [7:0] pwm_config_reg;
   logic [1:0] irq_status;
   logic [1:0] irq_mask;

   wire [1:0] output_config = unit_control_reg[UC_CFG_HI:UC_CFG_LO];
   wire pwm_mode = unit_control_reg[UC_MODE_HI -: 2] == PWM_MODE_TOP;
   wire [2:0] shutdown_source_select = shdn_cfg[SC_SRC_HI:SC_SRC_LO];
   wire [1:0] pair_ac_shutdown_state = shdn_cfg[SC_AC_HI:SC_AC_LO];
   wire [1:0] pair_bd_shutdown_state = shdn_cfg[SC_BD_HI:SC_BD_LO];
   wire auto_restart_enable = pwm_config_reg[PC_RESTART];
   wire [6:0] dead_band_count = HAS_HALF_BRIDGE ? pwm_config_reg[PC_DB_HI:0] : 7'h00;
   wire enhanced = pwm_mode && (output_config != CFG_SINGLE);

   // live shutdown cause from the selected sources; zero select means none
   wire cause_sync = |(shutdown_source_select & trip_sync);
   // raw cause for the immediate, clockless override path
   wire [2:0] trip_raw = {~fault_input_n, cmp2_trip, cmp1_trip};
   wire cause_raw = |(shutdown_source_select & trip_raw);

   wire wr_unit = bus.wr && bus.addr == ADDR_UNIT_CTRL;
   wire wr_shdn = bus.wr && bus.addr == ADDR_SHDN_CTRL;
   wire wr_cfg = bus.wr && bus.addr == ADDR_PWM_CFG;
   wire wr_irq = bus.wr && bus.addr == ADDR_IRQ;

   ////////////////////////////////////////////////////////////////////////////
   // shutdown flag: hardware set beats any clear
   wire flag_set = enhanced && cause_sync;
   wire auto_clr = auto_restart_enable && !cause_sync;
   wire sw_write_ok = wr_shdn && !cause_sync;
   // software may only clear the flag; a written one is dropped so that no
   // shutdown can ever appear while every source is deselected
   logic next_flag;
   always_comb
   begin
      next_flag = shutdown_active_flag;
      if (sw_write_ok)
         next_flag = shutdown_active_flag && bus.wdata[SC_FLAG];
      if (auto_clr)
         next_flag = 1'b0;
      if (flag_set)
         next_flag = 1'b1;
   end

   // plain register writes
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         unit_control_reg <= RESET_BYTE;
         shdn_cfg <= 7'h00;
         pwm_config_reg <= RESET_BYTE;
         shutdown_active_flag <= 1'b0;
      end
      else
      begin
         if (wr_unit)
            unit_control_reg <= bus.wdata;
         if (wr_shdn)
            shdn_cfg <= bus.wdata[SC_SRC_HI:0];
         if (wr_cfg)
            pwm_config_reg <= bus.wdata;
         shutdown_active_flag <= next_flag;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupts: shutdown entry and restart events, write one to clear
   logic flag_d;
   wire [1:0] irq_event = {flag_d & ~shutdown_active_flag, ~flag_d & shutdown_active_flag};
   always_ff @(posedge clk)
   begin
      if (srst)
      begin
         flag_d <= 1'b0;
         irq_status <= 2'h0;
         irq_mask <= 2'h0;
      end
      else
      begin
         flag_d <= shutdown_active_flag;
         irq_status <= (irq_status & ~(wr_irq ? bus.wdata[1:0] : 2'h0)) | irq_event;
         if (wr_irq && bus.wdata[7])
            irq_mask <= bus.wdata[5:4]; // bit 7 set selects mask update
      end
   end
   assign irq = |(irq_status & irq_mask);

   // read port, data in the following cycle
   logic [7:0] next_rdata;
   always_comb
   begin
      case (bus.addr)
         ADDR_UNIT_CTRL: next_rdata = unit_control_reg;
         ADDR_SHDN_CTRL: next_rdata = {shutdown_active_flag, shdn_cfg};
         ADDR_PWM_CFG: next_rdata = {auto_restart_enable, dead_band_count};
         ADDR_IRQ: next_rdata = {2'h0, irq_mask, 2'h0, irq_status};
         default: next_rdata = 8'h00;
      endcase
   end
   always_ff @(posedge clk)
   begin
      if (srst)
         rdata <= 8'h00;
      else if (bus.rd)
         rdata <= next_rdata;
      else
         rdata <= 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////
   // period-aligned shutdown hold: outputs resume only at a period start
   logic hold;
   always_ff @(posedge clk)
   begin
      if (srst)
         hold <= 1'b0;
      else if (flag_set || shutdown_active_flag)
         hold <= 1'b1;
      else if (period_start)
         hold <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////////
   // dead band: one counter per half-bridge leg, rising edges only
   logic [6:0] cnt_a;
   logic [6:0] cnt_b;
   logic lead_a;
   logic lead_b;
   wire half = pwm_mode && output_config == CFG_HALF;
   always_ff @(posedge clk)
   begin
      if (srst || !pwm_raw)
         cnt_a <= 7'h00;
      else if (cnt_a < dead_band_count)
         cnt_a <= cnt_a + 7'h01;
   end
   always_ff @(posedge clk)
   begin
      if (srst || pwm_raw)
         cnt_b <= 7'h00;
      else if (cnt_b < dead_band_count)
         cnt_b <= cnt_b + 7'h01;
   end
   // a leg goes active only when its counter reaches the count; drops at once
   assign lead_a = pwm_raw && cnt_a >= dead_band_count;
   assign lead_b = !pwm_raw && cnt_b >= dead_band_count;

   ////////////////////////////////////////////////////////////////////////////
   // output steering before polarity (active = 1)
   epw_pins_s act;
   epw_pins_s used;
   always_comb
   begin
      act = '0;
      used = '0;
      if (pwm_mode)
      begin
         case (output_config)
            CFG_SINGLE:
            begin
               act.a = pwm_raw;
               used = 4'b1000;
            end
            CFG_FWD:
            begin
               act.a = 1'b1;
               act.d = pwm_raw;
               used = 4'b1111;
            end
            CFG_HALF:
            begin
               act.a = lead_a;
               act.b = lead_b;
               used = 4'b1100;
            end
            CFG_REV:
            begin
               act.b = pwm_raw;
               act.c = 1'b1;
               used = 4'b1111;
            end
            default:
            begin
               act = '0;
               used = '0;
            end
         endcase
      end
   end

   // polarity per pair, then registered pin data
   wire pol_ac = unit_control_reg[UC_POL_AC];
   wire pol_bd = unit_control_reg[UC_POL_BD];
   epw_pins_s norm_q;
   always_ff @(posedge clk)
   begin
      if (srst)
         norm_q <= '0;
      else
         norm_q <= {act.a ^ pol_ac, act.b ^ pol_bd, act.c ^ pol_ac, act.d ^ pol_bd};
   end

   ////////////////////////////////////////////////////////////////////////////
   // clockless shutdown override, only in enhanced modes and on used pins
   wire shdn_now = enhanced && (cause_raw || hold || shutdown_active_flag);
   wire ac_hi = pair_ac_shutdown_state == SS_HIGH;
   wire bd_hi = pair_bd_shutdown_state == SS_HIGH;
   wire ac_drive = pair_ac_shutdown_state == SS_LOW || ac_hi;
   wire bd_drive = pair_bd_shutdown_state == SS_LOW || bd_hi;
   assign pin_out.a = shdn_now ? ac_hi : norm_q.a;
   assign pin_out.c = shdn_now ? ac_hi : norm_q.c;
   assign pin_out.b = shdn_now ? bd_hi : norm_q.b;
   assign pin_out.d = shdn_now ? bd_hi : norm_q.d;
   assign pin_oe.a = used.a && (!shdn_now || ac_drive);
   assign pin_oe.c = used.c && (!shdn_now || ac_drive);
   assign pin_oe.b = used.b && (!shdn_now || bd_drive);
   assign pin_oe.d = used.d && (!shdn_now || bd_drive);

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   sequence s_cause_seen;
      enhanced && cause_sync;
   endsequence
   sequence s_flag_up;
      ##1 shutdown_active_flag;
   endsequence
   sequence s_flag_drop;
      enhanced && $fell(shutdown_active_flag);
   endsequence
   sequence s_still_shut;
      shdn_now;
   endsequence

   a_flag_sets: assert property (@(posedge clk) disable iff (srst)
      s_cause_seen |-> s_flag_up)
      else $error("shutdown flag not set after cause");
   a_write_blocked: assert property (@(posedge clk) disable iff (srst)
      (cause_sync && shutdown_active_flag && wr_shdn) |=> shutdown_active_flag)
      else $error("flag cleared by write during cause");
   a_auto_restart: assert property (@(posedge clk) disable iff (srst)
      (auto_restart_enable && !cause_sync && !flag_set) |=> !shutdown_active_flag)
      else $error("auto restart did not clear flag");
   a_no_source: assert property (@(posedge clk) disable iff (srst)
      (shutdown_source_select == 3'h0 && !shutdown_active_flag) |=> !shutdown_active_flag)
      else $error("flag set with no source");
   a_hold_period: assert property (@(posedge clk) disable iff (srst)
      (hold && !period_start && enhanced) |=> hold)
      else $error("shutdown released mid period");
   a_outputs_held: assert property (@(posedge clk) disable iff (srst)
      (enhanced && shutdown_active_flag && ac_hi) |-> (pin_out.a && pin_out.c))
      else $error("pair a/c not held high");
   a_tri_state: assert property (@(posedge clk) disable iff (srst)
      (shdn_now && !ac_drive) |-> (!pin_oe.a && !pin_oe.c))
      else $error("tri-state pair still enabled");
   a_single_pins: assert property (@(posedge clk) disable iff (srst)
      (pwm_mode && output_config == CFG_SINGLE) |-> !(pin_oe.b || pin_oe.c || pin_oe.d))
      else $error("extra pins in single mode");
   a_dead_band: assert property (@(posedge clk) disable iff (srst)
      ($rose(pwm_raw) && dead_band_count != 7'h00) |-> !lead_a)
      else $error("rising edge not delayed");
   a_fall_now: assert property (@(posedge clk) disable iff (srst)
      !pwm_raw |-> !lead_a)
      else $error("falling edge delayed");
   a_resume_waits: assert property (@(posedge clk) disable iff (srst)
      s_flag_drop |-> s_still_shut)
      else $error("outputs resumed before period start");
   a_shdn_async: assert property (@(posedge clk) disable iff (srst)
      (enhanced && cause_raw && ac_hi) |-> pin_out.a)
      else $error("pair a/c not forced high by live cause");
   a_lead_b_delay: assert property (@(posedge clk) disable iff (srst)
      (half && $fell(pwm_raw) && dead_band_count != 7'h00) |-> !lead_b)
      else $error("leg b rising edge not delayed");
   a_pol_fwd: assert property (@(posedge clk) disable iff (srst)
      (pwm_mode && output_config == CFG_FWD) |=> norm_q.a == !$past(pol_ac))
      else $error("pair a/c polarity wrong");
   a_nohb_read: assert property (@(posedge clk) disable iff (srst)
      (bus.rd && bus.addr == ADDR_PWM_CFG && !HAS_HALF_BRIDGE) |=> rdata[6:0] == 7'h00)
      else $error("delay count visible without half-bridge");
   a_read_idle: assert property (@(posedge clk) disable iff (srst)
      !bus.rd |=> rdata == 8'h00)
      else $error("read data outside its cycle");
endmodule

/* File: core/epw_pkg.sv */
package epw_pkg;
   // register indices on the plain register port
   localparam logic [1:0] ADDR_UNIT_CTRL = 2'h0;
   localparam logic [1:0] ADDR_SHDN_CTRL = 2'h1;
   localparam logic [1:0] ADDR_PWM_CFG = 2'h2;
   localparam logic [1:0] ADDR_IRQ = 2'h3;
   localparam int ADDR_W = 2;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   // field positions
   localparam int UC_CFG_HI = 7;
   localparam int UC_CFG_LO = 6;
   localparam int UC_MODE_HI = 3;
   localparam int UC_POL_AC = 1;
   localparam int UC_POL_BD = 0;
   localparam int SC_FLAG = 7;
   localparam int SC_SRC_HI = 6;
   localparam int SC_SRC_LO = 4;
   localparam int SC_AC_HI = 3;
   localparam int SC_AC_LO = 2;
   localparam int SC_BD_HI = 1;
   localparam int SC_BD_LO = 0;
   localparam int PC_RESTART = 7;
   localparam int PC_DB_HI = 6;
   localparam int IRQ_SHDN = 0;
   localparam int IRQ_RESTART = 1;
   localparam logic [1:0] PWM_MODE_TOP = 2'h3;
   // output configurations
   localparam logic [1:0] CFG_SINGLE = 2'h0;
   localparam logic [1:0] CFG_FWD = 2'h1;
   localparam logic [1:0] CFG_HALF = 2'h2;
   localparam logic [1:0] CFG_REV = 2'h3;
   // shutdown pin states
   localparam logic [1:0] SS_LOW = 2'h0;
   localparam logic [1:0] SS_HIGH = 2'h1;
   // source select bits
   localparam int SRC_CMP1 = 0;
   localparam int SRC_CMP2 = 1;
   localparam int SRC_FAULT = 2;
   // instruction clock is the core clock: one delay count per cycle
   localparam int CLK_MHZ = 40;
   localparam int TCY_NS = 25;
   localparam int CYC_PER_COUNT = (TCY_NS * CLK_MHZ + 999) / 1000;

   typedef struct packed
   {
      logic [ADDR_W-1:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } epw_bus_s;

   typedef struct packed
   {
      logic a;
      logic b;
      logic c;
      logic d;
   } epw_pins_s;
endpackage

/* File: tb/epw_far_side.sv */
`timescale 1ns/1ps
// comparators and fault pin facing the block; each trip lands mid-cycle,
// so a pin change seen before the next edge can only come from an unclocked path
module epw_far_side
#(
   parameter int LAG_NS = 10
)
(
   input wire logic clk,
   input wire logic [2:0] req,
   output logic cmp1_trip,
   output logic cmp2_trip,
   output logic fault_input_n
);
   // quiet at power-up: no trip, fault pin idles high
   initial
   begin
      cmp1_trip = 1'b0;
      cmp2_trip = 1'b0;
      fault_input_n = 1'b1;
   end

   // any mix of the three sources may trip together
   always @(posedge clk)
   begin
      cmp1_trip <= #(LAG_NS) req[0];
      cmp2_trip <= #(LAG_NS) req[1];
      fault_input_n <= #(LAG_NS) ~req[2];
   end
endmodule

/* File: tb/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import epw_pkg::*;
   logic clk;
   logic srst;
   epw_bus_s bus;
   logic [7:0] rdata;
   logic [7:0] rdata2;
   logic [7:0] rv2;
   logic pwm_raw;
   logic period_start;
   logic [2:0] req;
   logic cmp1_trip;
   logic cmp2_trip;
   logic fault_input_n;
   epw_pins_s pin_out;
   epw_pins_s pin_oe;
   logic irq;
   int bad_count;
   int checks;
   int n0;
   int n1;
   localparam logic [7:0] MCFG [4] = '{8'h4c, 8'hcc, 8'hce, 8'hcd};
   localparam logic [3:0] MPIN [4] = '{4'b1001, 4'b0110, 4'b1100, 4'b0011};

   //////////////////////////////////////////////////
   // full variant plus one without half-bridge sharing all inputs
   epw_top #(.HAS_HALF_BRIDGE(1'b1)) u_dut (.clk(clk), .srst(srst), .bus(bus), .rdata(rdata),
      .pwm_raw(pwm_raw), .period_start(period_start), .cmp1_trip(cmp1_trip),
      .cmp2_trip(cmp2_trip), .fault_input_n(fault_input_n), .pin_out(pin_out),
      .pin_oe(pin_oe), .irq(irq));
   epw_top #(.HAS_HALF_BRIDGE(1'b0)) u_nohb (.clk(clk), .srst(srst), .bus(bus), .rdata(rdata2),
      .pwm_raw(pwm_raw), .period_start(period_start), .cmp1_trip(cmp1_trip),
      .cmp2_trip(cmp2_trip), .fault_input_n(fault_input_n), .pin_out(), .pin_oe(), .irq());
   epw_far_side #(.LAG_NS(10)) u_far (.clk(clk), .req(req), .cmp1_trip(cmp1_trip),
      .cmp2_trip(cmp2_trip), .fault_input_n(fault_input_n));

   // 40 MHz core clock
   initial
   begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   //////////////////////////////////////////////////
   task test_done;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task chk(input logic [7:0] got, input logic [7:0] want);
      checks++;
      if (got !== want)
      begin
         bad_count++;
         $display("MISMATCH t=%0t got %h want %h", $time, got, want);
      end
   endtask

   task tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // one-cycle strobes; the leading edge wait keeps back-to-back calls apart
   task wr(input logic [1:0] a, input logic [7:0] d);
      @(posedge clk);
      bus <= {a, d, 2'b10};
      @(posedge clk);
      bus <= '0;
   endtask

   task rdc(input logic [1:0] a, input logic [7:0] want);
      @(posedge clk);
      bus <= {a, 8'h00, 2'b01};
      @(posedge clk);
      bus <= '0;
      #1;
      chk(rdata, want);
      rv2 = rdata2;
   endtask

   // undriven pins are masked out, their value is meaningless
   task pins(input logic [3:0] v, input logic [3:0] oe);
      chk({4'h0, pin_out & pin_oe}, {4'h0, v});
      chk({4'h0, pin_oe}, {4'h0, oe});
   endtask

   task waitpin(input int i, input logic v, output int n);
      n = 0;
      do
      begin
         @(posedge clk);
         #1;
         n++;
      end
      while (pin_out[i] !== v && n < 40);
   endtask

   task setraw(input logic v);
      @(posedge clk);
      pwm_raw <= v;
   endtask

   // check point sits after the far side has moved but before the next edge
   task trip(input logic [2:0] r);
      @(posedge clk);
      req <= r;
      @(posedge clk);
      #12;
   endtask

   task pulse;
      @(posedge clk);
      period_start <= 1'b1;
      @(posedge clk);
      period_start <= 1'b0;
   endtask

   //////////////////////////////////////////////////
   task t_reset;
      for (int a = 0; a < 4; a++)
         rdc(a[1:0], RESET_BYTE);
      pins(4'h0, 4'h0);
      wr(ADDR_PWM_CFG, 8'h85);
      rdc(ADDR_PWM_CFG, 8'h85);
      chk(rv2, 8'h80);
      $display("test reset done");
   endtask

   task t_deadband;
      wr(ADDR_PWM_CFG, 8'h03);
      wr(ADDR_UNIT_CTRL, 8'h0c);
      setraw(1'b1);
      waitpin(3, 1'b1, n0);
      chk(n0[7:0], 8'h01);
      pins(4'b1000, 4'b1000);
      wr(ADDR_SHDN_CTRL, 8'h12);
      trip(3'b001);
      pins(4'b1000, 4'b1000);
      trip(3'b000);
      rdc(ADDR_SHDN_CTRL, 8'h12);
      setraw(1'b0);
      wr(ADDR_UNIT_CTRL, 8'h8c);
      tick(6);
      setraw(1'b1);
      waitpin(3, 1'b1, n1);
      chk(n1[7:0], n0[7:0] + 8'h03);
      setraw(1'b0);
      waitpin(3, 1'b0, n1);
      chk(n1[7:0], n0[7:0]);
      waitpin(2, 1'b1, n1);
      chk(n1[7:0], 8'h03);
      pins(4'b0100, 4'b1100);
      $display("test deadband done");
   endtask

   task t_modes;
      setraw(1'b1);
      for (int i = 0; i < 4; i++)
      begin
         wr(ADDR_UNIT_CTRL, MCFG[i]);
         tick(2);
         pins(MPIN[i], 4'hf);
      end
      $display("test modes done");
   endtask

   // software restart path with the interrupt raised, masked and cleared
   task t_latch;
      wr(ADDR_UNIT_CTRL, 8'h8c);
      tick(6);
      trip(3'b001);
      pins(4'b0000, 4'b1000);
      tick(4);
      rdc(ADDR_SHDN_CTRL, 8'h92);
      chk({7'h0, irq}, 8'h00);
      wr(ADDR_IRQ, 8'h90);
      tick(1);
      chk({7'h0, irq}, 8'h01);
      wr(ADDR_SHDN_CTRL, 8'h12);
      rdc(ADDR_SHDN_CTRL, 8'h92);
      trip(3'b000);
      pulse;
      tick(4);
      rdc(ADDR_SHDN_CTRL, 8'h92);
      pins(4'b0000, 4'b1000);
      wr(ADDR_SHDN_CTRL, 8'h12);
      rdc(ADDR_SHDN_CTRL, 8'h12);
      pins(4'b0000, 4'b1000);
      pulse;
      tick(6);
      pins(4'b1000, 4'b1100);
      wr(ADDR_IRQ, 8'h03);
      tick(1);
      chk({7'h0, irq}, 8'h00);
      $display("test latch done");
   endtask

   task t_auto;
      wr(ADDR_PWM_CFG, 8'h83);
      wr(ADDR_SHDN_CTRL, 8'h45);
      trip(3'b100);
      pins(4'b1100, 4'b1100);
      tick(4);
      rdc(ADDR_SHDN_CTRL, 8'hc5);
      trip(3'b000);
      tick(4);
      rdc(ADDR_SHDN_CTRL, 8'h45);
      pulse;
      tick(6);
      pins(4'b1000, 4'b1100);
      wr(ADDR_SHDN_CTRL, 8'h05);
      trip(3'b111);
      pins(4'b1000, 4'b1100);
      tick(4);
      rdc(ADDR_SHDN_CTRL, 8'h05);
      trip(3'b000);
      wr(ADDR_SHDN_CTRL, 8'h25);
      trip(3'b010);
      pins(4'b1100, 4'b1100);
      trip(3'b000);
      $display("test auto done");
   endtask

   // mid-run reset: every register, pin and the interrupt return to idle
   task t_rerun;
      @(posedge clk);
      srst <= 1'b1;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      for (int a = 0; a < 4; a++)
         rdc(a[1:0], RESET_BYTE);
      pins(4'h0, 4'h0);
      chk({7'h0, irq}, 8'h00);
      $display("test rerun done");
   endtask

   // compare mode with half-bridge bits set: no pins driven, trips ignored
   task t_off;
      wr(ADDR_SHDN_CTRL, 8'h15);
      wr(ADDR_UNIT_CTRL, 8'h88);
      trip(3'b001);
      pins(4'h0, 4'h0);
      tick(4);
      rdc(ADDR_SHDN_CTRL, 8'h15);
      trip(3'b000);
      $display("test off done");
   endtask

   //////////////////////////////////////////////////
   initial
   begin
      srst = 1'b1;
      bus = '0;
      pwm_raw = 1'b0;
      period_start = 1'b0;
      req = 3'h0;
      bad_count = 0;
      checks = 0;
      repeat (10) @(posedge clk);
      srst <= 1'b0;
      t_reset;
      t_deadband;
      t_modes;
      t_latch;
      t_auto;
      t_rerun;
      t_off;
      test_done;
   end

   // the whole run needs well under a thousand cycles; four thousand means a hang
   initial
   begin
      #(25 * 4000);
      bad_count++;
      test_done;
   end
endmodule
